//--- logic/gstc_capture.sv
// gstc_capture: free-running tick counter with second-marker and trigger
// captures, coincidence trigger and message-to-marker delay measurement.
// assumes: second marker and channel inputs are raw pins; the message
// strobe comes from same-clock serial decode logic; single clock domain.
`timescale 1ns/1ns
`include "gstc_defines.svh"

module gstc_capture #(
    parameter int NUM_CH    = `GSTC_NUM_CH,     // discriminator channels
    parameter int WIN_W     = `GSTC_WIN_W,      // window count width
    parameter int MS_CYCLES = `GSTC_MS_CYCLES   // clock cycles per ms
) (
    // clock, reset, enable
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    // receiver pins and decoded serial time
    input  wire logic                second_marker_pulse,
    input  wire logic                time_msg_strobe,
    // discriminator pins and window setting
    input  wire logic [NUM_CH-1:0]   chan_hit,
    input  wire logic [WIN_W-1:0]    coinc_window,
    // live counter
    output gstc_pkg::gstc_tick_t     tick_count,
    // second-marker record
    output logic                     marker_rec_valid,
    output gstc_pkg::gstc_tick_t     marker_capture,
    output gstc_pkg::gstc_tick_t     ticks_per_second,
    // event record
    output logic                     event_rec_valid,
    output gstc_pkg::gstc_tick_t     trig_capture,
    output gstc_pkg::gstc_tick_t     trig_offset,
    // delay carried in both records
    output gstc_pkg::gstc_delay_t    msg_delay_ms
);
    import gstc_pkg::*;

    localparam int MS_DIV_W = $clog2(MS_CYCLES + 1);  // ms divider width

    // synchronised pins
    logic              marker_rise;           // marker leading edge
    logic [NUM_CH-1:0] chan_rise;             // channel threshold crossings

    // counter and capture state
    gstc_tick_t tick_ff,   nxt_tick;          // free-running tick count
    gstc_tick_t mcap_ff,   nxt_mcap;          // latest marker capture
    gstc_tick_t tps_ff,    nxt_tps;           // ticks between two markers
    gstc_tick_t tcap_ff,   nxt_tcap;          // trigger capture
    gstc_tick_t toff_ff,   nxt_toff;          // trigger minus marker
    logic       mvalid_ff, nxt_mvalid;        // marker record pulse
    logic       evalid_ff, nxt_evalid;        // event record pulse

    // coincidence state
    gstc_coinc_t        cst_ff,  nxt_cst;     // window state
    logic [WIN_W-1:0]   win_ff,  nxt_win;     // cycles left in window
    logic [NUM_CH-1:0]  omask_ff, nxt_omask;  // channels that opened window
    logic               trig_hit;             // trigger this cycle

    // delay measurement state
    logic [MS_DIV_W-1:0] msdiv_ff, nxt_msdiv; // cycles inside current ms
    gstc_ms_t            msel_ff,  nxt_msel;  // ms since marker edge
    gstc_delay_t         dly_ff,   nxt_dly;   // folded signed delay

    // pin synchronisers, one per input pin
    gstc_pin_sync u_marker_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pin_in   (second_marker_pulse),
        .lvl      (),
        .rise     (marker_rise)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_chan_sync
            gstc_pin_sync u_chan_sync (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .ce       (ce),
                .pin_in   (chan_hit[gi]),
                .lvl      (),
                .rise     (chan_rise[gi])
            );
        end
    endgenerate

    // outputs straight from flip-flops
    assign tick_count       = tick_ff;
    assign marker_rec_valid = mvalid_ff;
    assign marker_capture   = mcap_ff;
    assign ticks_per_second = tps_ff;
    assign event_rec_valid  = evalid_ff;
    assign trig_capture     = tcap_ff;
    assign trig_offset      = toff_ff;
    assign msg_delay_ms     = dly_ff;

    // fold elapsed ms into a signed delay around the marker edge
    function automatic gstc_delay_t fold_delay(input gstc_ms_t ms);
        gstc_delay_t d;
        d = gstc_delay_t'({1'b0, ms});
        if (ms >= `GSTC_HALF_SEC_MS) begin
            d = d - gstc_delay_t'({1'b0, `GSTC_SEC_MS});  // message ahead
        end
        return d;
    endfunction : fold_delay

    // coincidence window: open on a crossing, trigger on a second channel
    always_comb begin
        nxt_cst   = cst_ff;
        nxt_win   = win_ff;
        nxt_omask = omask_ff;
        trig_hit  = 1'b0;
        case (cst_ff)
            GSTC_IDLE: begin
                if (chan_rise != '0) begin
                    if ((chan_rise & (chan_rise - NUM_CH'(1))) != '0) begin
                        trig_hit = 1'b1;              // two at once
                    end else if (coinc_window != '0) begin
                        nxt_cst   = GSTC_OPEN;
                        nxt_win   = coinc_window;
                        nxt_omask = chan_rise;
                    end
                end
            end
            GSTC_OPEN: begin
                if ((chan_rise & ~omask_ff) != '0) begin
                    trig_hit  = 1'b1;                 // other channel in window
                    nxt_cst   = GSTC_IDLE;
                    nxt_omask = '0;
                    nxt_win   = '0;
                end else if (win_ff == WIN_W'(1)) begin
                    nxt_cst   = GSTC_IDLE;            // window ran out
                    nxt_omask = '0;
                    nxt_win   = '0;
                end else begin
                    nxt_win = win_ff - WIN_W'(1);
                end
            end
            default: begin
                nxt_cst   = GSTC_IDLE;
                nxt_omask = '0;
                nxt_win   = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cst_ff   <= GSTC_IDLE;
            win_ff   <= '0;
            omask_ff <= '0;
        end else if (ce) begin
            cst_ff   <= nxt_cst;
            win_ff   <= nxt_win;
            omask_ff <= nxt_omask;
        end
    end

    // tick counter and captures
    always_comb begin
        nxt_tick   = tick_ff + gstc_tick_t'(1);       // one per enabled clock, wraps
        nxt_mcap   = mcap_ff;
        nxt_tps    = tps_ff;
        nxt_tcap   = tcap_ff;
        nxt_toff   = toff_ff;
        nxt_mvalid = 1'b0;
        nxt_evalid = 1'b0;
        if (marker_rise) begin
            nxt_mcap   = tick_ff;                     // hold for readout
            nxt_tps    = tick_ff - mcap_ff;           // mod 2^32 span
            nxt_mvalid = 1'b1;                        // record each marker
        end
        if (trig_hit) begin
            nxt_tcap   = tick_ff;
            // offset from the marker in force; a same-cycle marker counts
            if (marker_rise) begin
                nxt_toff = gstc_tick_t'(0);
            end else begin
                nxt_toff = tick_ff - mcap_ff;         // mod 2^32 numerator
            end
            nxt_evalid = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff   <= `GSTC_TICK_RST;
            mcap_ff   <= `GSTC_TICK_RST;
            tps_ff    <= `GSTC_TICK_RST;
            tcap_ff   <= `GSTC_TICK_RST;
            toff_ff   <= `GSTC_TICK_RST;
            mvalid_ff <= 1'b0;
            evalid_ff <= 1'b0;
        end else if (ce) begin
            tick_ff   <= nxt_tick;
            mcap_ff   <= nxt_mcap;
            tps_ff    <= nxt_tps;
            tcap_ff   <= nxt_tcap;
            toff_ff   <= nxt_toff;
            mvalid_ff <= nxt_mvalid;
            evalid_ff <= nxt_evalid;
        end
    end

    // millisecond clock since the marker edge, delay latch on message
    always_comb begin
        nxt_msdiv = msdiv_ff;
        nxt_msel  = msel_ff;
        nxt_dly   = dly_ff;
        if (marker_rise) begin
            nxt_msdiv = '0;                           // restart at the edge
            nxt_msel  = '0;
        end else if (msdiv_ff == MS_DIV_W'(MS_CYCLES - 1)) begin
            nxt_msdiv = '0;
            if (msel_ff != `GSTC_MS_SAT) begin
                nxt_msel = msel_ff + gstc_ms_t'(1);   // saturate, no wrap
            end
        end else begin
            nxt_msdiv = msdiv_ff + MS_DIV_W'(1);
        end
        if (time_msg_strobe) begin
            if (marker_rise) begin
                nxt_dly = '0;                         // message on the edge
            end else begin
                nxt_dly = fold_delay(msel_ff);        // signed ms delay
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            msdiv_ff <= '0;
            msel_ff  <= '0;
            dly_ff   <= '0;
        end else if (ce) begin
            msdiv_ff <= nxt_msdiv;
            msel_ff  <= nxt_msel;
            dly_ff   <= nxt_dly;
        end
    end

endmodule : gstc_capture

//--- logic/gstc_defines.svh
// gstc_defines.svh: widths, reset values and timing counts for the
// second-marker timestamp capture block.
// assumes: included by bare name from every gstc design file.
`ifndef GSTC_DEFINES_SVH
`define GSTC_DEFINES_SVH

`define GSTC_TICK_W        32
`define GSTC_TICK_RST      32'h0000_0000
`define GSTC_NUM_CH        4
`define GSTC_WIN_W         8
`define GSTC_DELAY_W       11
`define GSTC_MS_W          10
// clock period and one millisecond, in nanoseconds
`define GSTC_CLK_PERIOD_NS 50
`define GSTC_ONE_MS_NS     1000000
// cycles in one millisecond, rounded down
`define GSTC_MS_CYCLES     (`GSTC_ONE_MS_NS / `GSTC_CLK_PERIOD_NS)
// millisecond figures for delay folding
`define GSTC_SEC_MS        10'h3E8
`define GSTC_HALF_SEC_MS   10'h1F4
`define GSTC_MS_SAT        10'h3FF

`endif

//--- logic/gstc_pkg.sv
// gstc_pkg: types shared by the second-marker timestamp capture block.
// assumes: gstc_defines.svh is on the include path.
`include "gstc_defines.svh"

package gstc_pkg;
    typedef logic [`GSTC_TICK_W-1:0]         gstc_tick_t;   // tick counter word
    typedef logic signed [`GSTC_DELAY_W-1:0] gstc_delay_t;  // signed ms delay
    typedef logic [`GSTC_MS_W-1:0]           gstc_ms_t;     // ms since marker
    typedef enum logic [1:0] {
        GSTC_IDLE = 2'b00,   // no coincidence window open
        GSTC_OPEN = 2'b01    // coincidence window running
    } gstc_coinc_t;
endpackage : gstc_pkg

//--- logic/gstc_pin_sync.sv
// gstc_pin_sync: three-stage pin synchroniser with agreement filter and
// rising-edge pulse.
// assumes: pin is asynchronous to core_clk; ce freezes every stage.
`timescale 1ns/1ns
`include "gstc_defines.svh"

module gstc_pin_sync (
    // clock, reset, enable
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // raw pin
    input  wire logic pin_in,
    // filtered level and rising pulse
    output logic      lvl,
    output logic      rise
);
    logic s1_ff, s2_ff, s3_ff;   // synchroniser chain
    logic lvl_ff, rise_ff;       // accepted level, edge pulse
    logic nxt_lvl, nxt_rise;     // next values

    assign lvl  = lvl_ff;
    assign rise = rise_ff;

    // accept a change only once stages two and three agree
    always_comb begin
        nxt_lvl  = lvl_ff;
        nxt_rise = 1'b0;
        if (s2_ff == s3_ff) begin
            nxt_lvl  = s3_ff;
            nxt_rise = s3_ff & ~lvl_ff;  // one pulse per leading edge
        end
    end

    // registers only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff   <= 1'b0;
            s2_ff   <= 1'b0;
            s3_ff   <= 1'b0;
            lvl_ff  <= 1'b0;
            rise_ff <= 1'b0;
        end else if (ce) begin
            s1_ff   <= pin_in;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            lvl_ff  <= nxt_lvl;
            rise_ff <= nxt_rise;
        end
    end
endmodule : gstc_pin_sync

//--- test/gstc_capture_assertions.sv
// gstc_capture_assertions: port checks for the timestamp capture block.
// assumes: bound to gstc_capture; one clock domain.
`timescale 1ns/1ns
module gstc_capture_assertions (
    // clock, reset, enable
    input wire logic             core_clk,
    input wire logic             rst_n,
    input wire logic             ce,
    // receiver pins
    input wire logic             second_marker_pulse,
    input wire logic             time_msg_strobe,
    // live counter, records and delay
    input gstc_pkg::gstc_tick_t  tick_count,
    input wire logic             marker_rec_valid,
    input gstc_pkg::gstc_tick_t  marker_capture,
    input gstc_pkg::gstc_tick_t  ticks_per_second,
    input wire logic             event_rec_valid,
    input gstc_pkg::gstc_tick_t  trig_capture,
    input gstc_pkg::gstc_tick_t  trig_offset,
    input gstc_pkg::gstc_delay_t msg_delay_ms
);
    import gstc_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // counter and marker record
    // the release edge itself still sees reset, so the count starts one edge later
    a_tick_step: assert property (ce && rst_n |=> tick_count == $past(tick_count) + 1)
        else $error("tick counter did not advance by one");
    a_marker_lat: assert property (ce && $rose(second_marker_pulse) ##1
        (ce && second_marker_pulse)[*5] |-> marker_rec_valid)
        else $error("marker record late or missing");
    a_cap_value: assert property (marker_rec_valid && $past(ce) |->
        marker_capture == tick_count - 1)
        else $error("marker capture is not the tick of the edge");
    a_tps_diff: assert property (marker_rec_valid |->
        ticks_per_second == marker_capture - $past(marker_capture))
        else $error("ticks per second is not the capture difference");
    a_cap_hold: assert property (!marker_rec_valid |-> $stable(marker_capture))
        else $error("marker capture moved without a record");
    // event record and delay
    a_trig_off: assert property (event_rec_valid |->
        trig_offset == trig_capture - marker_capture)
        else $error("trigger offset wrong");
    a_trig_hold: assert property (!event_rec_valid |-> $stable(trig_capture))
        else $error("trigger capture moved without a record");
    a_delay_hold: assert property (!time_msg_strobe |=> $stable(msg_delay_ms))
        else $error("delay moved without a message");
    c_marker: cover property (marker_rec_valid);
    c_event: cover property (event_rec_valid);
    c_neg_delay: cover property (time_msg_strobe ##1 msg_delay_ms < 0);
endmodule : gstc_capture_assertions

bind gstc_capture gstc_capture_assertions u_chk (.core_clk, .rst_n, .ce,
    .second_marker_pulse, .time_msg_strobe, .tick_count, .marker_rec_valid,
    .marker_capture, .ticks_per_second, .event_rec_valid, .trig_capture,
    .trig_offset, .msg_delay_ms);

//--- test/gstc_gps_model.sv
// gstc_gps_model: receiver stand-in giving marker pulse and message strobe.
// assumes: core clock domain; counts shortened to cycles.
`timescale 1ns/1ns
module gstc_gps_model #(
    parameter int PERIOD = 4000,  // cycles per second, 1000 ms at 4 cycles per ms
    parameter int WIDTH  = 400    // marker high cycles, 100 ms
) (
    // clock and control
    input  wire logic core_clk,
    input  wire logic fixed,      // position fix held
    input  wire logic [31:0] msg_at,  // message cycle after marker edge
    // receiver outputs
    output logic      second_marker_pulse,
    output logic      time_msg_strobe
);
    int cnt = 0;  // cycle within the second
    // outputs settle low at the first edge, well inside reset
    // silent until fixed, then one marker and one message per second
    always @(posedge core_clk) begin
        if (!fixed) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        end
        second_marker_pulse <= fixed && (cnt < WIDTH);
        time_msg_strobe <= fixed && (cnt == msg_at);
    end
endmodule : gstc_gps_model

//--- test/tb_gstc_capture.sv
// tb_gstc_capture: self-checking bench for the timestamp capture block.
// assumes: receiver model on marker pins; bench drives channels and ce.
`timescale 1ns/1ns
module tb_gstc_capture;
    import gstc_pkg::*;
    localparam int WIN = 8;  // coincidence window cycles
    // stimulus
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        fixed = 1'b0;
    int          msg_at = 605;  // 150 ms after the synced edge
    logic [3:0]  chan_hit = 4'h0;
    logic [7:0]  coinc_window = 8'h08;
    // receiver model and design outputs
    logic        second_marker_pulse, time_msg_strobe, marker_rec_valid, event_rec_valid;
    gstc_tick_t  tick_count, marker_capture, ticks_per_second, trig_capture, trig_offset;
    gstc_delay_t msg_delay_ms;
    // bench model of the counter
    gstc_tick_t  ref_tick, mark_exp, last_exp, trig_exp;
    logic        pin_q = 1'b0;
    int          n_mismatch = 0;
    int          total_checks = 0;
    always #25 core_clk = ~core_clk;
    gstc_capture #(.MS_CYCLES(4)) dut (.core_clk, .rst_n, .ce, .second_marker_pulse,
        .time_msg_strobe, .chan_hit, .coinc_window, .tick_count, .marker_rec_valid,
        .marker_capture, .ticks_per_second, .event_rec_valid, .trig_capture,
        .trig_offset, .msg_delay_ms);
    gstc_gps_model u_gps (.core_clk, .fixed, .msg_at, .second_marker_pulse,
        .time_msg_strobe);
    // expected tick, one per enabled cycle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) ref_tick <= 32'h0000_0000;
        else if (ce) ref_tick <= ref_tick + 1;
    end
    // marker edge seen on the pin: capture lands four ticks later
    always @(negedge core_clk) begin
        if (second_marker_pulse && !pin_q) mark_exp <= ref_tick + 4;
        pin_q <= second_marker_pulse;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // bounded wait on a record flag or the strobe
    task automatic wait_for(input int sel, input int limit, input bit must, output bit got);
        got = 1'b0;
        for (int i = 0; i < limit && !got; i++) begin
            @(posedge core_clk);
            #1;
            got = (sel == 0) ? (marker_rec_valid === 1'b1) :
                  (sel == 1) ? (event_rec_valid === 1'b1) : (time_msg_strobe === 1'b1);
        end
        if (must && !got) begin
            n_mismatch++;
            $display("[FAIL] wait %0d ran out", sel);
            complete_run();
        end
    endtask : wait_for
    task automatic t_reset();
        check("reset tick", tick_count, 32'h0000_0000);
        check("reset capture", marker_capture | trig_capture, 32'h0000_0000);
        check("reset record", ticks_per_second | trig_offset, 32'h0000_0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        check("first tick", tick_count, 32'h0000_0001);
        $display("test reset done");
    endtask : t_reset
    task automatic t_marker();
        bit got;
        last_exp = 32'h0000_0000;
        fixed <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wait_for(0, 5000, 1'b1, got);
            check("marker capture", marker_capture, mark_exp);
            check("ticks per second", ticks_per_second, mark_exp - last_exp);
            last_exp = mark_exp;
        end
        check("live tick", tick_count, ref_tick);
        $display("test marker done");
    endtask : t_marker
    task automatic t_delay();
        bit got;
        wait_for(2, 4000, 1'b1, got);
        @(posedge core_clk);
        msg_at <= 2805;  // 700 ms: message ahead of next marker
        #1;
        check("delay positive", msg_delay_ms, 150);
        wait_for(2, 4000, 1'b1, got);
        @(posedge core_clk);
        fixed <= 1'b0;
        #1;
        check("delay negative", msg_delay_ms, -300);
        $display("test delay done");
    endtask : t_delay
    // opener a, then b after gap cycles; window boundary at gap == WIN
    task automatic t_pair(input logic [3:0] a, input logic [3:0] b, input int gap, input bit hit);
        bit got;
        @(posedge core_clk);
        if (gap > 0) chan_hit <= a;
        repeat (gap) @(posedge core_clk);
        chan_hit <= a | b;
        trig_exp = ref_tick + 5;
        wait_for(1, 12, 1'b0, got);
        check("trigger seen", got, hit);
        if (hit) check("trig capture", trig_capture, trig_exp);
        if (hit) check("trig offset", trig_offset, trig_exp - mark_exp);
        @(posedge core_clk);
        chan_hit <= 4'h0;
        repeat (WIN + 8) @(posedge core_clk);
    endtask : t_pair
    task automatic t_freeze();
        @(posedge core_clk);
        ce <= 1'b0;
        repeat (10) @(posedge core_clk);
        ce <= 1'b1;
        #1;
        check("frozen tick", tick_count, ref_tick);
        $display("test freeze done");
    endtask : t_freeze
    initial begin
        repeat (16) @(posedge core_clk);
        t_reset();
        t_marker();
        t_delay();
        t_pair(4'h1, 4'h2, WIN, 1'b1);
        t_pair(4'h1, 4'h2, WIN + 1, 1'b0);
        t_pair(4'h0, 4'hC, 0, 1'b1);
        // zero window: only simultaneous crossings may trigger
        coinc_window <= 8'h00;
        t_pair(4'h1, 4'h2, 1, 1'b0);
        $display("test coincidence done");
        t_freeze();
        complete_run();
    end
endmodule : tb_gstc_capture
